// file: inc/buck_config_map.vh
// Register offsets, field positions, reset values and decode constants
`ifndef BUCK_CONFIG_MAP_VH
`define BUCK_CONFIG_MAP_VH

`define CTRL_OFFSET        8'h00
`define VOUT_OFFSET        8'h01

`define CTRL_RSVD_BIT      7
`define CTRL_DISCH_BIT     6
`define CTRL_RAMP_HI       5
`define CTRL_RAMP_LO       4
`define CTRL_PEAK_BIT      3
`define CTRL_MODE_BIT      2
`define CTRL_COMB_BIT      1
`define CTRL_SWEN_BIT      0
`define VOUT_RSVD_BIT      7
`define VOUT_CODE_HI       6

`define RSVD_RESET         1'b0
`define PEAK_RESET         1'b1
`define MODE_RESET         1'b0
`define COMB_RESET         1'b0
`define SWEN_RESET         1'b0
`define DISCH_DEFAULT      1'b0
`define RAMP_DEFAULT       2'h0
`define VCODE_DEFAULT      7'h08

`define VCODE_MAX          7'h54
`define VOUT_BASE_MV       13'h0320
`define VOUT_STEP_MV       13'h0032
`define PEAK_LOW_MA        11'h1f4
`define PEAK_HIGH_MA       11'h7d0
`define RAMP_BASE_MS       4'h1

`define SLAVE_ADDR_DEFAULT 7'h1e
`define UNMAPPED_READ      8'h00

`endif

// file: core/line_sync.v
// Pin synchronisers and serial bus edge, start and stop detection
`timescale 1ns/1ps
module line_sync (
  input  wire core_clk,
  input  wire reset,
  input  wire scl_in,
  input  wire sda_in,
  input  wire en_pin,
  input  wire uvlo_fall,
  output wire scl_rise,
  output wire scl_fall,
  output wire sda_s,
  output wire start_det,
  output wire stop_det,
  output wire en_pin_s,
  output wire uvlo_s
);

  // Stage one only feeds stage two; stage three is the edge history
  reg [3:0] meta_ff;
  reg [3:0] sync_ff;
  reg [1:0] prev_ff;

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_ff <= 4'hb;
      sync_ff <= 4'hb;
      prev_ff <= 2'h3;
    end else begin
      meta_ff <= {uvlo_fall, en_pin, sda_in, scl_in};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff[1:0];
    end
  end

  assign scl_rise  = sync_ff[0] & ~prev_ff[0];
  assign scl_fall  = ~sync_ff[0] & prev_ff[0];
  assign sda_s     = sync_ff[1];
  assign start_det = sync_ff[0] & prev_ff[0] & prev_ff[1] & ~sync_ff[1];
  assign stop_det  = sync_ff[0] & prev_ff[0] & ~prev_ff[1] & sync_ff[1];
  assign en_pin_s  = sync_ff[2];
  // Reset value high keeps registers at default until the supply is seen good
  assign uvlo_s    = sync_ff[3];

endmodule // line_sync

// file: core/buck_config_registers.v
// Converter configuration registers with their two-wire serial slave
//
// Operation
// (R1) Bit 6 of 0x00 enables output discharge
// (R2) External-feedback build forces discharge permanently off
// (R3) Bits 5:4 select 1/2/4/8 ms ramp
// (R4) Bit 2: 0 pulse-skip, 1 forced PWM
// (R5) Combine-select 0: pin OR software enable
// (R6) Combine-select 1: pin AND software enable
// (R7) Bit 7 reserved, stored, readable, no effect
// (R8) Bits 6:0 of 0x01 hold voltage code
// (R9) Code 50 mV steps, saturates above 0x54
// (R10) Bit 3: 0 gives 500 mA, 1 gives 2000 mA
// (R11) Undervoltage lockout returns registers to defaults
// (R12) 8-bit registers, auto-incrementing serial reads, writes
`timescale 1ns/1ps
`include "buck_config_map.vh"
module buck_config_registers #(
  parameter       EXT_FEEDBACK  = 0,
  parameter [6:0] SLAVE_ADDR    = `SLAVE_ADDR_DEFAULT,
  parameter       DISCH_DEFAULT = `DISCH_DEFAULT,
  parameter [1:0] RAMP_DEFAULT  = `RAMP_DEFAULT,
  parameter [6:0] VCODE_DEFAULT = `VCODE_DEFAULT
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  input  wire        en_pin,
  input  wire        uvlo_fall,
  output reg         discharge_enable,
  output reg  [1:0]  ramp_time_sel,
  output reg  [3:0]  ramp_time_ms,
  output reg         peak_limit_high,
  output reg  [10:0] peak_limit_ma,
  output reg         forced_fixed_freq,
  output reg         converter_enable,
  output reg  [6:0]  target_voltage_code,
  output reg  [12:0] target_mv
);

  localparam [8:0] ST_IDLE  = 9'h001;
  localparam [8:0] ST_ADDR  = 9'h002;
  localparam [8:0] ST_AACK  = 9'h004;
  localparam [8:0] ST_PTR   = 9'h008;
  localparam [8:0] ST_PACK  = 9'h010;
  localparam [8:0] ST_WDATA = 9'h020;
  localparam [8:0] ST_WACK  = 9'h040;
  localparam [8:0] ST_RDATA = 9'h080;
  localparam [8:0] ST_MACK  = 9'h100;

  localparam [7:0] CTRL_RESET = {`RSVD_RESET, DISCH_DEFAULT[0], RAMP_DEFAULT, `PEAK_RESET,
                                 `MODE_RESET, `COMB_RESET, `SWEN_RESET};
  localparam [7:0] VOUT_RESET = {`RSVD_RESET, VCODE_DEFAULT};

  wire scl_rise;
  wire scl_fall;
  wire sda_s;
  wire start_det;
  wire stop_det;
  wire en_pin_s;
  wire uvlo_s;

  line_sync u_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .en_pin    (en_pin),
    .uvlo_fall (uvlo_fall),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .sda_s     (sda_s),
    .start_det (start_det),
    .stop_det  (stop_det),
    .en_pin_s  (en_pin_s),
    .uvlo_s    (uvlo_s)
  );

  reg [7:0] ctrl_ff;
  reg [7:0] vout_ff;
  reg [8:0] state_ff;
  reg [3:0] cnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] ptr_ff;
  reg [7:0] tx_ff;
  reg       rw_ff;
  reg       nack_ff;
  reg       ack_drive_ff;

  // Unmapped offsets read as zero
  function [7:0] reg_read;
    input [7:0] offs;
    input [7:0] ctrl;
    input [7:0] vout;
    begin
      case (offs)
        `CTRL_OFFSET: reg_read = ctrl;
        `VOUT_OFFSET: reg_read = vout;
        default:      reg_read = `UNMAPPED_READ;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Serial slave protocol engine

  wire addr_match = (shift_ff[7:1] == SLAVE_ADDR);
  wire byte_done  = (cnt_ff == 4'h8);
  wire wr_strobe  = (state_ff == ST_WDATA) && scl_fall && byte_done;

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 4'h0;
      shift_ff     <= 8'h00;
      ptr_ff       <= 8'h00;
      tx_ff        <= 8'h00;
      rw_ff        <= 1'b0;
      nack_ff      <= 1'b0;
      ack_drive_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff     <= ST_IDLE;
      ack_drive_ff <= 1'b0;
    end else if (start_det) begin
      state_ff     <= ST_ADDR;
      cnt_ff       <= 4'h0;
      ack_drive_ff <= 1'b0;
    end else begin
      if (scl_rise) begin
        shift_ff <= {shift_ff[6:0], sda_s};
        cnt_ff   <= cnt_ff + 4'h1;
        nack_ff  <= sda_s;
      end
      if (scl_fall) begin
        case (state_ff)
          ST_IDLE: begin
            state_ff <= ST_IDLE;
          end
          ST_ADDR: begin
            if (byte_done) begin
              if (addr_match) begin
                state_ff     <= ST_AACK;
                rw_ff        <= shift_ff[0];
                ack_drive_ff <= 1'b1;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            cnt_ff       <= 4'h0;
            ack_drive_ff <= 1'b0;
            if (rw_ff) begin
              // Read starts at the pointer left by the last access
              state_ff <= ST_RDATA;
              tx_ff    <= reg_read(ptr_ff, ctrl_ff, vout_ff);
              ptr_ff   <= ptr_ff + 8'h01; // see (R12)
            end else begin
              state_ff <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (byte_done) begin
              state_ff     <= ST_PACK;
              ptr_ff       <= shift_ff;
              ack_drive_ff <= 1'b1;
            end
          end
          ST_PACK, ST_WACK: begin
            state_ff     <= ST_WDATA;
            cnt_ff       <= 4'h0;
            ack_drive_ff <= 1'b0;
          end
          ST_WDATA: begin
            if (byte_done) begin
              state_ff     <= ST_WACK;
              ptr_ff       <= ptr_ff + 8'h01; // see (R12)
              ack_drive_ff <= 1'b1;
            end
          end
          ST_RDATA: begin
            if (byte_done) begin
              state_ff <= ST_MACK;
            end else begin
              tx_ff <= {tx_ff[6:0], 1'b0};
            end
          end
          ST_MACK: begin
            cnt_ff <= 4'h0;
            if (nack_ff) begin
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_RDATA;
              tx_ff    <= reg_read(ptr_ff, ctrl_ff, vout_ff);
              ptr_ff   <= ptr_ff + 8'h01; // see (R12)
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = ack_drive_ff | ((state_ff == ST_RDATA) & ~tx_ff[7]);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= CTRL_RESET;
      vout_ff <= VOUT_RESET;
    end else if (uvlo_s) begin
      // Lockout outranks a write landing in the same cycle
      ctrl_ff <= CTRL_RESET; // see (R11)
      vout_ff <= VOUT_RESET; // see (R11)
    end else if (wr_strobe) begin
      // All eight bits stored, reserved bit included
      if (ptr_ff == `CTRL_OFFSET) begin
        ctrl_ff <= shift_ff; // see (R7)
      end
      if (ptr_ff == `VOUT_OFFSET) begin
        vout_ff <= shift_ff; // see (R8)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded controls for the analog side

  wire [6:0]  code_sat = (vout_ff[`VOUT_CODE_HI:0] > `VCODE_MAX) ? `VCODE_MAX
                                                                : vout_ff[`VOUT_CODE_HI:0];
  wire [12:0] code_w   = {6'h00, code_sat};
  wire        sw_en    = ctrl_ff[`CTRL_SWEN_BIT];

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      discharge_enable    <= 1'b0;
      ramp_time_sel       <= 2'h0;
      ramp_time_ms        <= `RAMP_BASE_MS;
      peak_limit_high     <= `PEAK_RESET;
      peak_limit_ma       <= `PEAK_HIGH_MA;
      forced_fixed_freq   <= 1'b0;
      converter_enable    <= 1'b0;
      target_voltage_code <= 7'h00;
      target_mv           <= `VOUT_BASE_MV;
    end else begin
      discharge_enable    <= (EXT_FEEDBACK != 0) ? 1'b0 // see (R2)
                                                 : ctrl_ff[`CTRL_DISCH_BIT]; // see (R1)
      ramp_time_sel       <= ctrl_ff[`CTRL_RAMP_HI:`CTRL_RAMP_LO]; // see (R3)
      ramp_time_ms        <= `RAMP_BASE_MS << ctrl_ff[`CTRL_RAMP_HI:`CTRL_RAMP_LO]; // see (R3)
      peak_limit_high     <= ctrl_ff[`CTRL_PEAK_BIT]; // see (R10)
      peak_limit_ma       <= ctrl_ff[`CTRL_PEAK_BIT] ? `PEAK_HIGH_MA : `PEAK_LOW_MA; // see (R10)
      forced_fixed_freq   <= ctrl_ff[`CTRL_MODE_BIT]; // see (R4)
      if (ctrl_ff[`CTRL_COMB_BIT]) begin
        converter_enable <= en_pin_s & sw_en; // see (R6)
      end else begin
        converter_enable <= en_pin_s | sw_en; // see (R5)
      end
      target_voltage_code <= vout_ff[`VOUT_CODE_HI:0]; // see (R8)
      target_mv           <= `VOUT_BASE_MV + code_w * `VOUT_STEP_MV; // see (R9)
    end
  end

endmodule // buck_config_registers

// file: verif/buck_config_assertions.sv
// Port-level checker for the converter configuration registers
`timescale 1ns/1ps
module buck_config_checker #(
  parameter       EXT_FEEDBACK  = 0,
  parameter [6:0] VCODE_DEFAULT = 7'h08
) (
  input wire        core_clk,
  input wire        reset,
  input wire        scl_in,
  input wire        en_pin,
  input wire        uvlo_fall,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        discharge_enable,
  input wire [1:0]  ramp_time_sel,
  input wire [3:0]  ramp_time_ms,
  input wire        peak_limit_high,
  input wire [10:0] peak_limit_ma,
  input wire        forced_fixed_freq,
  input wire        converter_enable,
  input wire [6:0]  target_voltage_code,
  input wire [12:0] target_mv
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_ramp_decode: assert property (ramp_time_ms == (4'h1 << ramp_time_sel))
    else $error("ramp time decode wrong");
  a_peak_decode: assert property (peak_limit_ma ==
    (peak_limit_high ? 11'h7d0 : 11'h1f4)) else $error("peak limit decode wrong");
  a_mv_decode: assert property (target_mv == 13'h0320 + 13'h0032 *
    ((target_voltage_code > 7'h54) ? 13'h0054 : {6'h00, target_voltage_code}))
    else $error("target voltage decode wrong");
  a_sda_low: assert property (sda_out == 1'b0)
    else $error("data pin value not low");
  // Slave may only move the data line while the clock is low
  a_sda_quiet: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved with clock high");
  a_disch_ext: assert property ((EXT_FEEDBACK != 0) |-> !discharge_enable)
    else $error("discharge on in external build");
  a_uvlo_dflt: assert property (uvlo_fall [*7] |->
    target_voltage_code == VCODE_DEFAULT && peak_limit_high && !forced_fixed_freq)
    else $error("lockout did not restore defaults");
  a_en_or_hi: assert property ((uvlo_fall && en_pin) [*7] |-> converter_enable)
    else $error("pin alone did not enable");
  a_en_or_lo: assert property ((uvlo_fall && !en_pin) [*7] |-> !converter_enable)
    else $error("enabled with pin and bit low");
  a_cfg_stable: assert property ((scl_in && !uvlo_fall) [*8] |->
    $stable(target_voltage_code) && $stable(ramp_time_sel)) else $error("config moved idle");
  c_uvlo: cover property (uvlo_fall [*7]);
  c_ack: cover property ($rose(sda_oe));
  c_sat: cover property (target_voltage_code > 7'h54);
endmodule // buck_config_checker
////////////////////////////////////////////////////////////////////////////////
bind buck_config_registers buck_config_checker #(.EXT_FEEDBACK(EXT_FEEDBACK),
  .VCODE_DEFAULT(VCODE_DEFAULT)) buck_config_checker_inst (.core_clk, .reset, .scl_in,
  .en_pin, .uvlo_fall, .sda_out, .sda_oe, .discharge_enable, .ramp_time_sel, .ramp_time_ms,
  .peak_limit_high, .peak_limit_ma, .forced_fixed_freq, .converter_enable,
  .target_voltage_code, .target_mv);

// file: verif/i2c_host.sv
// Two-wire bus master model that drives the configuration slave
`timescale 1ns/1ps
module i2c_host (
  input  wire       core_clk,
  input  wire       sda,
  output reg        scl,
  output reg        sda_m,
  output reg        got,
  output reg  [7:0] rdata,
  output reg        nak
);
  integer k;
  initial begin
    {scl, sda_m, got, rdata, nak} = {2'h3, 1'b0, 8'h00, 1'b0};
  end
  // Eight clocks a phase stay well past the slave's pin synchroniser
  task hp;
    begin
      repeat (8) @(posedge core_clk);
      #1;
    end
  endtask
  // Data moves two clocks after the fall so no false start or stop is seen
  task bitx(input b, output r);
    begin
      sda_m = b;
      hp;
      scl = 1'b1;
      hp;
      r = sda;
      scl = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
    end
  endtask
  task start;
    begin
      sda_m = 1'b1;
      hp;
      scl = 1'b1;
      hp;
      sda_m = 1'b0;
      hp;
      scl = 1'b0;
      hp;
    end
  endtask
  task stop;
    begin
      sda_m = 1'b0;
      hp;
      scl = 1'b1;
      hp;
      sda_m = 1'b1;
      hp;
    end
  endtask
  task tx(input [7:0] d);
    reg r;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitx(d[k], r);
      bitx(1'b1, nak);
    end
  endtask
  task rx(input last);
    reg r;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitx(1'b1, rdata[k]);
      got = 1'b1;
      @(posedge core_clk);
      #1 got = 1'b0;
      bitx(last, r);
    end
  endtask
endmodule // i2c_host

// file: verif/test_buck_config_registers.sv
// Self-checking testbench for the converter configuration registers
`timescale 1ns/1ps
module test_buck_config_registers;
  reg         core_clk = 1'b0, reset = 1'b1, en_pin = 1'b0, uvlo_fall = 1'b0;
  wire        scl_in, sda_m, sda_out, sda_oe, got, nak, discharge_enable, peak_limit_high;
  wire        forced_fixed_freq, converter_enable;
  wire [1:0]  ramp_time_sel;
  wire [3:0]  ramp_time_ms;
  wire [10:0] peak_limit_ma;
  wire [6:0]  target_voltage_code;
  wire [12:0] target_mv;
  wire [7:0]  rdata;
  wire        ext_sda_oe, ext_discharge;
  wire        sda_in = sda_m & ~sda_oe & ~ext_sda_oe;
  integer     failures = 0, tests_run = 0, i, j;
  reg  [7:0]  exp_q [$];
  reg  [7:0]  a, b, e;
  always #2 core_clk = ~core_clk;
  buck_config_registers buck_config_registers_inst (.core_clk, .reset, .scl_in, .sda_in,
    .sda_out, .sda_oe, .en_pin, .uvlo_fall, .discharge_enable, .ramp_time_sel, .ramp_time_ms,
    .peak_limit_high, .peak_limit_ma, .forced_fixed_freq, .converter_enable,
    .target_voltage_code, .target_mv);
  i2c_host i2c_host_inst (.core_clk, .sda(sda_in), .scl(scl_in), .sda_m, .got, .rdata, .nak);
  // External-feedback build on the same bus: same address, same answers
  if (1) begin : ext_build
    buck_config_registers #(.EXT_FEEDBACK(1)) buck_config_registers_inst (
      .core_clk(core_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(),
      .sda_oe(ext_sda_oe), .en_pin(en_pin), .uvlo_fall(uvlo_fall),
      .discharge_enable(ext_discharge), .ramp_time_sel(), .ramp_time_ms(),
      .peak_limit_high(), .peak_limit_ma(), .forced_fixed_freq(), .converter_enable(),
      .target_voltage_code(), .target_mv());
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [63:0] what, input [12:0] exp, input [12:0] seen);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task tx(input [7:0] d);
    begin
      i2c_host_inst.tx(d);
      chk("ack", 13'h0000, nak);
    end
  endtask
  task wr(input [7:0] d0, input [7:0] d1, input two);
    begin
      i2c_host_inst.start;
      tx(8'h3c);
      tx(8'h00);
      tx(d0);
      if (two) tx(d1);
      i2c_host_inst.stop;
    end
  endtask
  task rd(input integer n);
    begin
      i2c_host_inst.start;
      tx(8'h3c);
      tx(8'h00);
      i2c_host_inst.start;
      tx(8'h3d);
      for (j = 0; j < n; j = j + 1)
        i2c_host_inst.rx(j == n - 1);
      i2c_host_inst.stop;
    end
  endtask
  task lockout;
    begin
      uvlo_fall = 1'b1;
      repeat (8) @(posedge core_clk);
      #1 uvlo_fall = 1'b0;
    end
  endtask
  always @(posedge core_clk) if (got === 1'b1) begin
    e = exp_q.pop_front();
    chk("rdata", e, rdata);
  end
  initial begin
    #200000;
    failures = failures + 1;
    final_report;
  end
  initial begin
    void'($urandom(32'hd03bcd62));
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    repeat (6) @(posedge core_clk);
    #1 exp_q = '{8'h08, 8'h08, 8'h00};
    rd(3);
    for (i = 0; i < 4; i = i + 1) begin
      a = 8'($urandom);
      b = 8'($urandom);
      a[5:4] = i[1:0];
      a[6] = i[0];
      if (i > 1) b[6:0] = 7'h52 + 7'(i);
      wr(a, b, 1'b1);
      repeat (4) @(posedge core_clk);
      #1 chk("ramp_ms", 13'h0001 << i, ramp_time_ms);
      chk("ramp_sel", i[1:0], ramp_time_sel);
      chk("peak_ma", a[3] ? 13'h07d0 : 13'h01f4, peak_limit_ma);
      chk("peak_hi", a[3], peak_limit_high);
      chk("forced_fixed_freq", a[2], forced_fixed_freq);
      chk("disch", a[6], discharge_enable);
      chk("dext", 13'h0000, ext_discharge);
      chk("vcode", b[6:0], target_voltage_code);
      chk("mv", 13'h0320 + 13'h0032 * (b[6:0] > 7'h54 ? 7'h54 : b[6:0]), target_mv);
      exp_q.push_back(a);
      exp_q.push_back(b);
      rd(2);
    end
    lockout;
    for (i = 0; i < 8; i = i + 1) begin
      en_pin = i[2];
      wr({6'h02, i[1:0]}, 8'h00, 1'b0);
      repeat (5) @(posedge core_clk);
      #1 chk("enable", i[1] ? i[2] & i[0] : i[2] | i[0], converter_enable);
    end
    wr(8'hff, 8'hff, 1'b1);
    lockout;
    exp_q.push_back(8'h08);
    exp_q.push_back(8'h08);
    rd(2);
    // Read from where the pointer stopped, past the mapped pair
    exp_q.push_back(8'h00);
    i2c_host_inst.start;
    tx(8'h3d);
    i2c_host_inst.rx(1'b1);
    i2c_host_inst.stop;
    i2c_host_inst.start;
    i2c_host_inst.tx(8'h48);
    chk("nack", 13'h0001, nak);
    i2c_host_inst.stop;
    final_report;
  end
endmodule // test_buck_config_registers
